/* testbench/bcr_host_model.sv */
// Purpose: host side of the register strobe port
// Assumes: one access every two cycles, signals change 1 ns after the edge
// Notes:   write data is inverted once the strobe drops
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model
   import bcr_pkg::*;
(
   input  wire logic         mclk,
   output var  bcr_reg_req_t regReq,
   input  wire logic [7:0]   regRdData
);
   initial regReq = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) #1;
      regReq = '{wr: 1'b1, addr: a, wdata: d};
      @(posedge mclk) #1;
      regReq.wr = 1'b0;
      regReq.wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) #1;
      regReq.addr = a;
      @(posedge mclk) #1;
      d = regRdData;
   endtask
endmodule
`default_nettype wire

/* testbench/buck_converter_control_regs_test.sv */
// Purpose: self-checking bench for the buck control register bank
// Assumes: slew base shortened to 64 cycles
// Notes:   pins held at 101 so 12h reads bits 7:5 as 101
`timescale 1ns/1ps
`default_nettype none
module buck_converter_control_regs_test;
   import bcr_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} bcr_row_t;
   logic           mclk = 1'b0;
   logic           rst = 1'b0;
   logic           ce = 1'b1;
   logic [2:0]     gpioPin = 3'b101;
   logic [NCH-1:0] pinStandbyCtrl = '0;
   bcr_reg_req_t   regReq;
   logic [7:0]     regRdData;
   logic [7:0]     d;
   bcr_buck_ctl_t  buck1Ctl;
   bcr_buck_ctl_t  buck2Ctl;
   logic [1:0]     phaseOffset;
   int             fails = 0;
   int             total_checks = 0;
   int             n;
   bcr_row_t rows [8] = '{'{8'h10, 8'hFF, 8'hFF}, '{8'h11, 8'hFF, 8'h7F}, '{8'h12, 8'hFF, 8'hBF},
      '{8'h13, 8'hA5, 8'hA5}, '{8'h14, 8'hFF, 8'h67}, '{8'h15, 8'hFF, 8'h1F}, '{8'h16, 8'hFF, 8'h00},
      '{8'h0F, 8'hFF, 8'h00}};
   logic [7:0] rv [6] = '{8'h10, 8'h16, 8'hB0, 8'h1D, 8'h06, 8'h1D};
   always #5 mclk = ~mclk;
   bcr_regs #(.SLEW_BASE_CYCLES(64)) i_bcr_regs (.mclk(mclk), .rst(rst), .ce(ce), .regReq(regReq),
      .regRdData(regRdData), .gpioPin(gpioPin), .pinStandbyCtrl(pinStandbyCtrl), .buck1Ctl(buck1Ctl),
      .buck2Ctl(buck2Ctl), .phaseOffset(phaseOffset));
   bcr_host_model i_bcr_host_model (.mclk(mclk), .regReq(regReq), .regRdData(regRdData));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic do_reset();
      #1 rst = 1'b1;
      repeat (10) @(posedge mclk);
      #1 rst = 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      complete_run();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         i_bcr_host_model.wr(rows[i].a, rows[i].w);
         i_bcr_host_model.rd(rows[i].a, d);
         chk(d, rows[i].e);
      end
      repeat (3) @(posedge mclk);
      chk(phaseOffset, 2'h3);
      chk(buck1Ctl, 10'h3DF);
      $display("register table test done");
      do_reset();
      chk(phaseOffset, 2'h2);
      chk(buck1Ctl, 10'h090);
      chk(buck2Ctl, 10'h09D);
      for (int i = 0; i < 6; i++) begin
         i_bcr_host_model.rd(8'h10 + 8'(i), d);
         chk(d, rv[i]);
      end
      $display("reset value test done");
      i_bcr_host_model.wr(8'h11, 8'h07);
      i_bcr_host_model.wr(8'h10, 8'hC5);
      repeat (3) @(posedge mclk);
      chk(buck1Ctl, 10'h385);
      i_bcr_host_model.wr(8'h13, 8'h3D);
      i_bcr_host_model.wr(8'h15, 8'h19);
      chk(buck2Ctl.pulseSkipMode, 1'b0);
      pinStandbyCtrl = 2'b10;
      for (n = 0; n < 40 && buck2Ctl.targetCode !== 5'h19; n++) @(posedge mclk) #1;
      chk(n, 4);
      chk(buck2Ctl.pulseSkipMode, 1'b1);
      i_bcr_host_model.wr(8'h14, 8'h00);
      pinStandbyCtrl = 2'b00;
      repeat (30) @(posedge mclk);
      chk(buck2Ctl.targetCode, 5'h19);
      chk(buck2Ctl.slewing, 1'b1);
      chk(buck2Ctl.pulseSkipMode, 1'b0);
      // slowest code: 64 cycles per step, 30 already spent
      for (n = 0; n < 80 && buck2Ctl.targetCode !== 5'h1A; n++) @(posedge mclk) #1;
      chk(n, 34);
      // write while clock enable is low must not land
      ce = 1'b0;
      i_bcr_host_model.wr(8'h13, 8'h00);
      ce = 1'b1;
      i_bcr_host_model.rd(8'h13, d);
      chk(d, 8'h3D);
      $display("slew and standby test done");
      complete_run();
   end
endmodule
`default_nettype wire

/* verilog/bcr_pkg.sv */
// Purpose: constants and types for the buck converter control register bank
// Assumes: 8-bit registers, 100 MHz mclk
// Notes:   two channels, channel stride of three addresses
package bcr_pkg;
   localparam int NCH = 2;
   localparam int VW  = 5;

   localparam logic [7:0] ADDR_B1_MAIN   = 8'h10;
   localparam logic [7:0] ADDR_B1_SET2   = 8'h11;
   localparam logic [7:0] ADDR_B1_STBY   = 8'h12;
   localparam logic [7:0] ADDR_B2_MAIN   = 8'h13;
   localparam logic [7:0] ADDR_B2_SET2   = 8'h14;
   localparam logic [7:0] ADDR_B2_STBY   = 8'h15;
   localparam logic [7:0] ADDR_MAIN [NCH] = '{ADDR_B1_MAIN, ADDR_B2_MAIN};
   localparam logic [7:0] ADDR_SET2 [NCH] = '{ADDR_B1_SET2, ADDR_B2_SET2};
   localparam logic [7:0] ADDR_STBY [NCH] = '{ADDR_B1_STBY, ADDR_B2_STBY};

   // main settings fields
   localparam int ENABLE_BIT   = 7;
   localparam int RIPPLE_BIT   = 6;
   localparam int PWMONLY_BIT  = 5;
   // second settings fields
   localparam int STANDBY_BIT  = 6;
   localparam int DISCH_BIT    = 5;
   localparam int PHASE_LSB    = 3;
   localparam int SLEW_LSB     = 0;
   // standby register pin level field
   localparam int PIN_LSB      = 5;

   // 1.24 V on channel 1, 3.32 V on channel 2
   localparam logic [VW-1:0] B1_VCODE_RST = 5'h10;
   localparam logic [VW-1:0] B2_VCODE_RST = 5'h1D;
   localparam logic [1:0]    PHASE_RST    = 2'h2;
   localparam logic [2:0]    SLEW_RST     = 3'h6;
   localparam logic [2:0]    SLEW_IMMED   = 3'h7;

   localparam logic [7:0] MAIN_RST [NCH] = '{8'h0010, 8'h001D};
   localparam logic [7:0] SET2_RST [NCH] = '{8'h0016, 8'h0006};
   localparam logic [7:0] STBY_RST [NCH] = '{8'h0010, 8'h001D};
   localparam logic [7:0] MAIN_MASK [NCH] = '{8'h00FF, 8'h00FF};
   localparam logic [7:0] SET2_MASK [NCH] = '{8'h007F, 8'h0067};
   localparam logic [7:0] STBY_MASK [NCH] = '{8'h001F, 8'h001F};
   localparam logic       PIN_SHOWN [NCH] = '{1'b1, 1'b0};

   // slowest slew: one 40 mV code step at 0.24 mV/us (80 mV at 0.48 on channel 2)
   localparam int CLK_PERIOD_NS     = 10;
   localparam int STEP_UV           = 40000;
   localparam int SLOW_RATE_UV_US   = 240;
   localparam int SLEW_BASE_NS      = STEP_UV * 1000 / SLOW_RATE_UV_US;
   localparam int SLEW_BASE_CYC     = SLEW_BASE_NS / CLK_PERIOD_NS;
   localparam int CNT_W             = 15;

   typedef struct packed {
      logic          wr;
      logic [7:0]    addr;
      logic [7:0]    wdata;
   } bcr_reg_req_t;

   typedef struct packed {
      logic          enable;
      logic          rippleSelect;
      logic          pulseSkipMode;
      logic          dischargeEnable;
      logic          slewing;
      logic [VW-1:0] targetCode;
   } bcr_buck_ctl_t;
endpackage

/* verilog/bcr_regs.sv */
// Purpose: control register bank and voltage slew stepper for two buck channels
// Assumes: register port driven by an on-chip serial engine on mclk
// Notes:   pin levels are synchronised before use
// Behaviour
// R1: six registers at addresses 10h through 15h
// R2: reset voltage codes 1.24 V and 3.32 V
// R3: phase field bits 4:3, reset 180 degrees
// R4: channel 1 slew code, reset 110
// R5: channel 2 slew code, reset 110
// R6: defined defaults; pin levels read-only bits 7:5
// R7: standby forces pulse skip and standby code
// R8: ripple bit passed to comparator control
// R9: target stepped at slew rate, 111 immediate
// R10: pin controls may also request standby
// R11: enable, ripple, pwm-only, standby, discharge bit positions
`timescale 1ns/1ps
`default_nettype none
module bcr_regs
   import bcr_pkg::*;
#(
   parameter int SLEW_BASE_CYCLES = SLEW_BASE_CYC
) (
   input  wire logic          mclk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire bcr_reg_req_t  regReq,
   output var  logic [7:0]    regRdData,
   input  wire logic [2:0]    gpioPin,
   input  wire logic [NCH-1:0] pinStandbyCtrl,
   output var  bcr_buck_ctl_t buck1Ctl,
   output var  bcr_buck_ctl_t buck2Ctl,
   output var  logic [1:0]    phaseOffset
);
   localparam logic [CNT_W-1:0] BASE = CNT_W'(SLEW_BASE_CYCLES);

   logic [2:0]          pinMeta_reg;
   logic [2:0]          pinSync_reg;
   logic [NCH-1:0][7:0] mainV;
   logic [NCH-1:0][7:0] set2V;
   logic [NCH-1:0][7:0] stbyV;
   logic [NCH-1:0][VW-1:0] curV;
   logic [NCH-1:0][VW-1:0] goalV;
   logic [NCH-1:0]      standbyEff;
   bcr_buck_ctl_t       ctlV [NCH];
   logic [7:0]          rdData_reg;
   logic [7:0]          rdData_next;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinMeta_reg <= 3'h0;
         pinSync_reg <= 3'h0;
      end else if (ce) begin
         pinMeta_reg <= gpioPin;
         pinSync_reg <= pinMeta_reg;
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic [7:0]       main_reg, main_next;
      logic [7:0]       set2_reg, set2_next;
      logic [7:0]       stby_reg, stby_next;
      logic [VW-1:0]    cur_reg, cur_next;
      logic [CNT_W-1:0] cnt_reg, cnt_next;
      bcr_buck_ctl_t    ctl_reg, ctl_next;
      logic             stbyReq;
      logic [VW-1:0]    goal;
      logic [2:0]       slew;
      logic [CNT_W-1:0] interval;

      always_comb begin
         main_next = main_reg;
         set2_next = set2_reg;
         stby_next = stby_reg;
         if (regReq.wr) begin
            if (regReq.addr == ADDR_MAIN[g]) begin
               main_next = regReq.wdata & MAIN_MASK[g]; // R1
            end
            if (regReq.addr == ADDR_SET2[g]) begin
               set2_next = regReq.wdata & SET2_MASK[g]; // R1
            end
            if (regReq.addr == ADDR_STBY[g]) begin
               stby_next = regReq.wdata & STBY_MASK[g]; // R6
            end
         end
      end

      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            main_reg <= MAIN_RST[g]; // R2
            set2_reg <= SET2_RST[g]; // R3 R4 R5
            stby_reg <= STBY_RST[g]; // R2 R6
         end else if (ce) begin
            main_reg <= main_next;
            set2_reg <= set2_next;
            stby_reg <= stby_next;
         end
      end

      // standby from register bit or pin control
      assign stbyReq  = set2_reg[STANDBY_BIT] | pinStandbyCtrl[g]; // R7 R10 R11
      assign goal     = stbyReq ? stby_reg[VW-1:0] : main_reg[VW-1:0]; // R7
      assign slew     = set2_reg[SLEW_LSB +: 3];
      assign interval = BASE >> slew; // R4 R5

      always_comb begin
         cur_next = cur_reg;
         cnt_next = '0;
         if (cur_reg != goal) begin
            if (slew == SLEW_IMMED) begin
               cur_next = goal; // R9
            end else if (CNT_W'(cnt_reg + 1'b1) >= interval) begin
               cur_next = (goal > cur_reg) ? VW'(cur_reg + 1'b1) : VW'(cur_reg - 1'b1); // R9
            end else begin
               cnt_next = CNT_W'(cnt_reg + 1'b1);
            end
         end
         ctl_next.enable          = main_reg[ENABLE_BIT]; // R11
         ctl_next.rippleSelect    = main_reg[RIPPLE_BIT]; // R8
         ctl_next.pulseSkipMode   = ~main_reg[PWMONLY_BIT] | stbyReq; // R7
         ctl_next.dischargeEnable = set2_reg[DISCH_BIT]; // R11
         ctl_next.slewing         = (cur_next != goal);
         ctl_next.targetCode      = cur_next;
      end

      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            cur_reg <= STBY_RST[g][VW-1:0];
            cnt_reg <= '0;
            ctl_reg <= '{enable: 1'b0, rippleSelect: 1'b0, pulseSkipMode: 1'b1,
                         dischargeEnable: 1'b0, slewing: 1'b0, targetCode: STBY_RST[g][VW-1:0]};
         end else if (ce) begin
            cur_reg <= cur_next;
            cnt_reg <= cnt_next;
            ctl_reg <= ctl_next;
         end
      end

      assign mainV[g]      = main_reg;
      assign set2V[g]      = set2_reg;
      assign stbyV[g]      = stby_reg;
      assign curV[g]       = cur_reg;
      assign goalV[g]      = goal;
      assign standbyEff[g] = stbyReq;
      assign ctlV[g]       = ctl_reg;
   end

   always_comb begin
      rdData_next = 8'h00;
      for (int c = 0; c < NCH; c++) begin
         if (regReq.addr == ADDR_MAIN[c]) begin
            rdData_next = mainV[c];
         end
         if (regReq.addr == ADDR_SET2[c]) begin
            rdData_next = set2V[c];
         end
         if (regReq.addr == ADDR_STBY[c]) begin
            rdData_next = stbyV[c];
            if (PIN_SHOWN[c]) begin
               rdData_next[PIN_LSB +: 3] = pinSync_reg; // R6
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdData_reg <= 8'h00;
      end else if (ce) begin
         rdData_reg <= rdData_next;
      end
   end

   assign regRdData   = rdData_reg;
   assign buck1Ctl    = ctlV[0];
   assign buck2Ctl    = ctlV[1];
   assign phaseOffset = set2V[0][PHASE_LSB +: 2]; // R3

   sequence s_wr_main1;
      ce && regReq.wr && regReq.addr == ADDR_B1_MAIN;
   endsequence
   sequence s_rd_main1;
      ce && !regReq.wr && regReq.addr == ADDR_B1_MAIN;
   endsequence

   a_main_store: assert property (@(posedge mclk) disable iff (rst) // R1
      s_wr_main1 |=> mainV[0] == $past(regReq.wdata)) else $error("main write not stored");
   a_read_back: assert property (@(posedge mclk) disable iff (rst) // R1
      s_wr_main1 ##1 s_rd_main1 |=> regRdData == $past(regReq.wdata, 2)) else $error("read back wrong");
   a_reset_codes: assert property (@(posedge mclk) // R2
      rst |-> mainV[0][VW-1:0] == B1_VCODE_RST && stbyV[1][VW-1:0] == B2_VCODE_RST)
      else $error("reset voltage code wrong");
   a_phase_reset: assert property (@(posedge mclk) // R3
      rst |-> phaseOffset == PHASE_RST) else $error("phase reset wrong");
   a_slew1_reset: assert property (@(posedge mclk) // R4
      rst |-> set2V[0][2:0] == SLEW_RST) else $error("slew 1 reset wrong");
   a_slew2_reset: assert property (@(posedge mclk) // R5
      rst |-> set2V[1][2:0] == SLEW_RST) else $error("slew 2 reset wrong");
   a_pin_readonly: assert property (@(posedge mclk) disable iff (rst) // R6
      ce && regReq.wr && regReq.addr == ADDR_B1_STBY |=> stbyV[0][7:5] == 3'h0)
      else $error("pin level bits written");
   a_standby_pfm: assert property (@(posedge mclk) disable iff (rst) // R7
      ce && standbyEff[0] |=> buck1Ctl.pulseSkipMode) else $error("standby without pulse skip");
   a_ripple_follow: assert property (@(posedge mclk) disable iff (rst) // R8
      ce |=> buck2Ctl.rippleSelect == $past(mainV[1][RIPPLE_BIT])) else $error("ripple not followed");
   a_slew_immed: assert property (@(posedge mclk) disable iff (rst) // R9
      ce && set2V[0][2:0] == SLEW_IMMED && curV[0] != goalV[0] |=> curV[0] == $past(goalV[0]))
      else $error("immediate change missed");
   a_step_size: assert property (@(posedge mclk) disable iff (rst) // R9
      ce && set2V[1][2:0] != SLEW_IMMED |=>
      (curV[1] == $past(curV[1]) || curV[1] == VW'($past(curV[1]) + 1'b1) || curV[1] == VW'($past(curV[1]) - 1'b1)))
      else $error("slew step too large");
   a_pin_standby: assert property (@(posedge mclk) disable iff (rst) // R10
      pinStandbyCtrl[1] |-> goalV[1] == stbyV[1][VW-1:0]) else $error("pin standby ignored");
   a_enable_bit: assert property (@(posedge mclk) disable iff (rst) // R11
      ce |=> buck2Ctl.enable == $past(mainV[1][ENABLE_BIT])) else $error("enable not followed");
endmodule
`default_nettype wire
